// ### verilog/aras_pkg.sv
// Package of constants and types for the address recovery stack
//
// Operation
// RULE1 - Capture address at address strobe falling edge
// RULE2 - Each capture pushes history one slot deeper
// RULE3 - History holds exactly four addresses
// RULE4 - History readable at extended locations 4Eh, 4Fh
// RULE5 - Host selects bank via 0Ah, then latches 4Eh
// RULE6 - Reading 4Eh returns address two pushes back
// RULE7 - Host sets bank select bit before extended access
// RULE8 - History locations are read-only to host writes
package aras_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int STACK_DEPTH = 4;

   // ----------------------------------------------------------------
   // Register offsets and slot indices
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_LOST_ADDRESS_SLOT = 8'h4e;
   localparam logic [7:0] OFF_ADDRESS_HISTORY_UPPER = 8'h4f;
   localparam int SLOT_CURRENT = 0;
   localparam int SLOT_PREV = 1;
   localparam int SLOT_LOST = 2;
   localparam int SLOT_UPPER = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ENTRY = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [STACK_DEPTH-1:0][ADDR_W-1:0] aras_hist_t;

   typedef struct packed {
      logic ale;
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [ADDR_W-1:0] ad;
   } aras_bus_in_t;

   typedef enum logic [2:0] {
      ARAS_IDLE = 3'b001,
      ARAS_ADDR = 3'b010,
      ARAS_DRIVE = 3'b100
   } aras_phase_t;

   typedef struct packed {
      aras_phase_t phase;
      logic ale;
      logic [ADDR_W-1:0] rd_data;
   } aras_state_t;

   typedef struct packed {
      aras_hist_t hist;
   } aras_stack_state_t;

endpackage : aras_pkg

// ### verilog/aras_stack.sv
// Four-deep push-only address history
`timescale 1ns/1ps
module aras_stack
   import aras_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic push_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output aras_hist_t hist_o
);

   aras_stack_state_t st_q;
   aras_stack_state_t st_d;
   aras_hist_t shifted;

   // ----------------------------------------------------------------
   // Shift network
   // ----------------------------------------------------------------
   // RULE1 new current address
   assign shifted[0] = addr_i;

   // RULE2 older slots shift deeper
   // RULE3 deepest entry falls off
   for (genvar i = 1; i < DEPTH; i++) begin : g_shift
      assign shifted[i] = st_q.hist[i-1];
   end

   always_comb begin
      st_d = st_q;
      if (push_i) begin
         st_d.hist = shifted;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // One register process, so the whole history has a single driver
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '{hist: {DEPTH{RST_ENTRY}}};
      end else begin
         st_q <= st_d;
      end
   end

   assign hist_o = st_q.hist;

endmodule : aras_stack

// ### verilog/aras_top.sv
// Address recovery stack on the multiplexed host bus
`timescale 1ns/1ps
module aras_top
   import aras_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ale_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [ADDR_W-1:0] ad_i,
   input wire logic bank_select_bit_i,
   output logic [ADDR_W-1:0] ad_o,
   output logic ad_oe_o,
   output logic [ADDR_W-1:0] current_addr_o,
   output logic [ADDR_W-1:0] prev_addr_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   aras_bus_in_t bus;
   aras_state_t st_q;
   aras_state_t st_d;
   aras_hist_t hist;
   logic ale_fall;
   logic hit_lost;
   logic hit_upper;
   logic read_now;
   logic write_now;

   assign bus = '{ale: ale_i, cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i, ad: ad_i};

   // ----------------------------------------------------------------
   // Address strobe edge
   // ----------------------------------------------------------------
   // RULE1 falling strobe edge
   assign ale_fall = st_q.ale & ~bus.ale;

   // ----------------------------------------------------------------
   // History storage
   // ----------------------------------------------------------------
   aras_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .push_i(ale_fall),
      .addr_i(bus.ad),
      .hist_o(hist)
   );

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // RULE4 extended bank decode
   // Decode uses the latched address, so 4Eh sees the post-push slot
   assign hit_lost = hist[SLOT_CURRENT] == OFF_LOST_ADDRESS_SLOT;
   assign hit_upper = hist[SLOT_CURRENT] == OFF_ADDRESS_HISTORY_UPPER;
   assign read_now = ~bus.cs_n & ~bus.rd_n & bank_select_bit_i & (hit_lost | hit_upper) & ~ale_fall;
   // RULE8 writes are decoded only to be ignored
   assign write_now = ~bus.cs_n & ~bus.wr_n & bank_select_bit_i & (hit_lost | hit_upper);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.ale = bus.ale;
      case (st_q.phase)
         ARAS_IDLE: begin
            if (ale_fall) begin
               st_d.phase = ARAS_ADDR;
            end
         end
         ARAS_ADDR: begin
            if (read_now) begin
               st_d.phase = ARAS_DRIVE;
            end
         end
         ARAS_DRIVE: begin
            if (ale_fall || !read_now) begin
               st_d.phase = ARAS_ADDR;
            end
         end
         default: begin
            st_d.phase = ARAS_IDLE;
         end
      endcase
      if (read_now) begin
         // RULE6 lost address from slot two
         st_d.rd_data = hit_lost ? hist[SLOT_LOST] : hist[SLOT_UPPER];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '{phase: ARAS_IDLE, ale: 1'b0, rd_data: RST_READ_DATA};
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Drive only one cycle after the decoded read, trades latency for clean timing
   assign ad_o = st_q.rd_data;
   assign ad_oe_o = st_q.phase == ARAS_DRIVE;
   assign current_addr_o = hist[SLOT_CURRENT];
   assign prev_addr_o = hist[SLOT_PREV];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_strobe_fall;
      ale_fall;
   endsequence

   sequence s_read_lost;
      read_now && hit_lost;
   endsequence

   sequence s_read_upper;
      read_now && hit_upper;
   endsequence

   sequence s_bus_idle;
      !read_now;
   endsequence

   sequence s_refused;
      !bank_select_bit_i || !(hit_lost || hit_upper);
   endsequence

   capture_addr_a: // RULE1
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_strobe_fall |=> hist[SLOT_CURRENT] == $past(bus.ad))
      else $error("latched address not captured");

   push_shift_a: // RULE2
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_strobe_fall |=> (hist[SLOT_PREV] == $past(hist[SLOT_CURRENT]))
         && (hist[SLOT_LOST] == $past(hist[SLOT_PREV]))
         && (hist[SLOT_UPPER] == $past(hist[SLOT_LOST])))
      else $error("history did not shift on push");

   depth_hold_a: // RULE3
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !ale_fall |=> $stable(hist))
      else $error("history moved without a push");

   // Pushes three cycles apart leave no room for a hidden push
   two_back_a: // RULE6
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_strobe_fall ##3 s_strobe_fall ##3 s_strobe_fall |=> hist[SLOT_LOST] == $past(bus.ad, 7))
      else $error("slot two is not two pushes back");

   read_lost_a: // RULE6
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_read_lost |=> ad_oe_o && (ad_o == $past(hist[SLOT_LOST])))
      else $error("4Eh read returned wrong data");

   read_upper_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_read_upper |=> ad_oe_o && (ad_o == $past(hist[SLOT_UPPER])))
      else $error("4Fh read returned wrong data");

   bank_gate_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !bank_select_bit_i || bus.cs_n || bus.rd_n |=> !ad_oe_o)
      else $error("bus driven outside a valid read");

   write_ignored_a: // RULE8
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      write_now && !ale_fall |=> $stable(hist))
      else $error("write changed the history");

   // ----------------------------------------------------------------
   // Read path and address port checks
   // ----------------------------------------------------------------
   drive_gate_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_bus_idle |=> !ad_oe_o)
      else $error("drive without a decoded read");

   data_keep_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_bus_idle |=> $stable(ad_o))
      else $error("read data moved without a read");

   fall_no_drive_a: // RULE1
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_strobe_fall |=> !ad_oe_o)
      else $error("drive started on an address strobe");

   phase_onehot_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $onehot(st_q.phase))
      else $error("bus phase left its legal codes");

   write_no_drive_a: // RULE8
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      write_now && bus.rd_n |=> !ad_oe_o)
      else $error("write to history drove the bus");

   port_view_a: // RULE2
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_strobe_fall |=> (current_addr_o == $past(bus.ad)) && (prev_addr_o == $past(current_addr_o)))
      else $error("address ports did not follow the push");

   read_refuse_a: // RULE4
   assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_refused |=> !ad_oe_o)
      else $error("refused read drove the bus");

endmodule : aras_top

// ### sim/aras_host_model.sv
// Host processor model for the multiplexed bus
`timescale 1ns/1ps
module aras_host_model
   import aras_pkg::*;
#(
   parameter int BANK_POS = 4
) (
   input wire logic core_clk_i,
   input wire logic [ADDR_W-1:0] rd_data_i,
   input wire logic drive_i,
   output logic ale_o,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [ADDR_W-1:0] ad_o,
   output logic bank_select_bit_o
);
   logic [ADDR_W-1:0] last_q;
   initial begin
      ale_o = 1'b0;
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      ad_o = 8'h5c;
      bank_select_bit_o = 1'b0;
      last_q = 8'h00;
   end
   task automatic latch(input logic [ADDR_W-1:0] a);
      @(posedge core_clk_i);
      ale_o <= 1'b1;
      @(posedge core_clk_i);
      ale_o <= 1'b0;
      ad_o <= a;
      last_q = a;
      @(posedge core_clk_i);
      // Released lines show the inverse, not a stale address
      ad_o <= ~a;
   endtask : latch
   task automatic write(input logic [ADDR_W-1:0] d);
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      ad_o <= d;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      cs_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      ad_o <= ~d;
      if (last_q == 8'h0a) bank_select_bit_o <= d[BANK_POS];
   endtask : write
   task automatic set_bank(input logic b);
      latch(8'h0a);
      write({ADDR_W{b}});
   endtask : set_bank
   // Fixed one-cycle answer, request held over it
   task automatic read(output logic got, output logic [ADDR_W-1:0] data);
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      rd_n_o <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      got = drive_i;
      data = rd_data_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
   endtask : read
endmodule : aras_host_model

// ### sim/tb_address_recovery_stack.sv
// Testbench for the address recovery stack
`timescale 1ns/1ps
module tb_address_recovery_stack;
   import aras_pkg::*;
   logic core_clk_i, rst_n_i, ale, cs_n, rd_n, wr_n, bank, ad_oe, got;
   logic [ADDR_W-1:0] ad, ad_o, cur, prev, data;
   int fail_count = 0;
   int checks_done = 0;
   aras_top aras_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ale_i(ale), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_i(ad), .bank_select_bit_i(bank), .ad_o(ad_o), .ad_oe_o(ad_oe),
      .current_addr_o(cur), .prev_addr_o(prev));
   aras_host_model aras_host_model_inst (.core_clk_i(core_clk_i), .rd_data_i(ad_o), .drive_i(ad_oe),
      .ale_o(ale), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ad_o(ad), .bank_select_bit_o(bank));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic check_byte(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] act, input string what);
      checks_done++;
      if (act !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : check_byte
   task automatic check_bit(input logic exp, input logic act, input string what);
      checks_done++;
      if (act !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : check_bit
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // Settled mid-cycle; back-to-back latches stay three cycles apart
   task automatic check_hist(input logic [ADDR_W-1:0] c, input logic [ADDR_W-1:0] p);
      @(negedge core_clk_i);
      check_byte(c, cur, "current slot");
      check_byte(p, prev, "previous slot");
   endtask : check_hist
   // Drive must drop the cycle after the read ends
   task automatic read_expect(input logic e_oe, input logic [ADDR_W-1:0] e_data);
      aras_host_model_inst.read(got, data);
      check_bit(e_oe, got, "read drive");
      if (e_oe) check_byte(e_data, data, "read data");
      repeat (2) @(posedge core_clk_i);
      check_bit(1'b0, ad_oe, "drive release");
   endtask : read_expect
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_push;
      aras_host_model_inst.latch(8'h11);
      check_hist(8'h11, 8'h00);
      aras_host_model_inst.latch(8'h22);
      check_hist(8'h22, 8'h11);
      aras_host_model_inst.latch(8'h33);
      check_hist(8'h33, 8'h22);
   endtask : t_push
   task automatic t_recover;
      aras_host_model_inst.latch(8'h5a);
      aras_host_model_inst.set_bank(1'b1);
      aras_host_model_inst.latch(8'h4e);
      check_hist(8'h4e, 8'h0a);
      read_expect(1'b1, 8'h5a);
      aras_host_model_inst.latch(8'h4f);
      // Oldest entry 33 is gone, 4Fh holds 5a
      read_expect(1'b1, 8'h5a);
   endtask : t_recover
   task automatic t_readonly;
      aras_host_model_inst.latch(8'h4e);
      aras_host_model_inst.write(8'hff);
      check_bit(1'b0, ad_oe, "write drive");
      check_hist(8'h4e, 8'h4f);
      read_expect(1'b1, 8'h4e);
   endtask : t_readonly
   task automatic t_refuse;
      aras_host_model_inst.set_bank(1'b0);
      aras_host_model_inst.latch(8'h4e);
      read_expect(1'b0, 8'h00);
      aras_host_model_inst.set_bank(1'b1);
      read_expect(1'b0, 8'h00);
   endtask : t_refuse
   initial begin
      rst_n_i = 1'b0;
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      check_hist(8'h00, 8'h00);
      t_push();
      t_recover();
      t_readonly();
      t_refuse();
      complete_run();
   end
   // Bounded run: a hang counts as a mismatch
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end
endmodule : tb_address_recovery_stack
